//--- phydl_pkg.sv
package phydl_pkg;

    // Clock and bit periods
    localparam int              CLK_NS       = 10;
    localparam int              BIT_NS_100   = 10;
    localparam int              BIT_NS_10    = 100;
    localparam logic [3:0]      BIT_CYC_100  = 4'(BIT_NS_100 / CLK_NS);
    localparam logic [3:0]      BIT_CYC_10   = 4'(BIT_NS_10 / CLK_NS);

    // Word carried from the link side: {serial, data}
    localparam int              NIB_W        = 4;
    localparam int              WORD_W       = NIB_W + 1;
    localparam int              WORD_SER     = NIB_W;
    localparam logic [2:0]      NIB_BITS     = 3'h4;
    localparam logic [2:0]      SER_BITS     = 3'h1;
    localparam logic [1:0]      RX_NIB_LAST  = 2'h3;
    localparam int              FIFO_WORDS   = 4;

    // Carrier and collision counts in bit ticks, sync and output stages excluded
    localparam logic [4:0]      CRS_ON_BITS  = 5'h08;
    localparam logic [4:0]      COL_ON_BITS  = 5'h07;
    localparam logic [4:0]      CRS_OFF_BITS = 5'h0C;

    // Reset timing
    localparam int              CNT_W         = 26;
    localparam int              POR_MS        = 45;
    localparam int              CLKV_MS       = 35;
    localparam logic [CNT_W-1:0] POR_CYC      = CNT_W'(POR_MS * 1000000 / CLK_NS);
    localparam logic [CNT_W-1:0] CLKV_CYC     = CNT_W'(CLKV_MS * 1000000 / CLK_NS);
    localparam int              HWRST_MIN_NS  = 500;
    localparam logic [5:0]      HWRST_MIN_CYC = 6'((HWRST_MIN_NS + CLK_NS - 1) / CLK_NS);

    // Line serializer states
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } phydl_tx_e;

endpackage : phydl_pkg

//--- phydl_fifo.sv
module phydl_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wrPtr;
        logic [AW:0]                 rdPtr;
    } phydl_fifo_s;

    phydl_fifo_s st;
    phydl_fifo_s next_st;

    // Extra pointer bit tells full from empty; depth must be a power of two
    assign outValid = st.wrPtr != st.rdPtr;
    assign inReady  = !(st.wrPtr[AW] != st.rdPtr[AW] && st.wrPtr[AW-1:0] == st.rdPtr[AW-1:0]);
    assign outData  = st.mem[st.rdPtr[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        next_st = st;
        if (inValid && inReady) begin
            next_st.mem[st.wrPtr[AW-1:0]] = inData;
            next_st.wrPtr = st.wrPtr + (AW+1)'(1);
        end
        if (outValid && outReady) begin
            next_st.rdPtr = st.rdPtr + (AW+1)'(1);
        end
        if (clear) begin
            next_st.wrPtr = '0;
            next_st.rdPtr = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : phydl_fifo

//--- phydl_core.sv
module phydl_core
    import phydl_pkg::*;
#(
    parameter logic [CNT_W-1:0] POR_CYCLES       = POR_CYC,
    parameter logic [CNT_W-1:0] CLK_VALID_CYCLES = CLKV_CYC,
    parameter int               FIFO_DEPTH       = FIFO_WORDS
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             txLinkClk,
    input  wire logic             speed100,
    input  wire logic             fullDuplex,
    input  wire logic             serialMode,
    input  wire logic             txEn,
    input  wire logic [NIB_W-1:0] txd,
    input  wire logic             serialTxEnable,
    input  wire logic             serialTxBit,
    output logic                  txAccept,
    input  wire logic             hardwareResetLow,
    input  wire logic             lineReceivePair,
    input  wire logic             lineReceiveActive,
    output logic                  lineTransmitPair,
    output logic                  lineTransmitEnable,
    output logic                  crs,
    output logic                  col,
    output logic      [NIB_W-1:0] rxd,
    output logic                  rxDv,
    output logic                  txClkValid,
    output logic                  isolated
);

    // Reload value of a bit-time divider for the current speed
    function automatic logic [3:0] bitReload(input logic fast);
        return fast ? (BIT_CYC_100 - 4'h1) : (BIT_CYC_10 - 4'h1);
    endfunction : bitReload

    typedef struct packed {
        logic              hwS1;
        logic              hwS2;
        logic              rxBitS1;
        logic              rxBitS2;
        logic              rxValS1;
        logic              rxValS2;
        logic              reqS1;
        logic              reqS2;
        logic              enS1;
        logic              enS2;
        logic              ack;
        logic [5:0]        hwLowCnt;
        logic [CNT_W-1:0]  porCnt;
        logic              porDone;
        logic [CNT_W-1:0]  cvCnt;
        logic              txClkValid;
        logic              isolated;
        phydl_tx_e         txState;
        logic [3:0]        txDiv;
        logic [NIB_W-1:0]  txShift;
        logic [2:0]        txLeft;
        logic              lineTx;
        logic              lineTxEn;
        logic              rxPrev;
        logic [3:0]        rxDiv;
        logic [NIB_W-1:0]  rxShift;
        logic [1:0]        rxCnt;
        logic [4:0]        rxOn;
        logic [4:0]        rxOff;
        logic              rxOffRun;
        logic [NIB_W-1:0]  rxd;
        logic              rxDv;
        logic              crs;
        logic              col;
    } phydl_core_s;

    typedef struct packed {
        logic              cvS1;
        logic              cvS2;
        logic              modeS1;
        logic              modeS2;
        logic              ackS1;
        logic              ackS2;
        logic              req;
        logic [WORD_W-1:0] word;
        logic              enLvl;
    } phydl_link_s;

    phydl_core_s      c;
    phydl_core_s      next_c;
    phydl_link_s      l;
    phydl_link_s      next_l;
    logic             rstS1;
    logic             rstS2;
    logic             linkRstS1;
    logic             linkRstS2;
    logic             run;
    logic             fifoInValid;
    logic             fifoInReady;
    logic             fifoOutValid;
    logic             fifoOutReady;
    logic [WORD_W-1:0] fifoOut;
    logic             linkPending;
    logic             linkEnIn;

    // Reset release through two stages in each domain
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstS1 <= 1'b0;
            rstS2 <= 1'b0;
        end else begin
            rstS1 <= 1'b1;
            rstS2 <= rstS1;
        end
    end

    always_ff @(posedge txLinkClk or negedge nrst) begin
        if (!nrst) begin
            linkRstS1 <= 1'b0;
            linkRstS2 <= 1'b0;
        end else begin
            linkRstS1 <= 1'b1;
            linkRstS2 <= linkRstS1;
        end
    end

    // Link side: one word in flight, held stable until the toggle returns
    assign linkPending = l.req != l.ackS2;
    assign linkEnIn    = l.modeS2 ? serialTxEnable : txEn;
    assign txAccept    = !linkPending && l.cvS2;

    always_comb begin
        next_l        = l;
        next_l.cvS1   = c.txClkValid && !c.isolated;
        next_l.cvS2   = l.cvS1;
        next_l.modeS1 = serialMode;
        next_l.modeS2 = l.modeS1;
        next_l.ackS1  = c.ack;
        next_l.ackS2  = l.ackS1;
        next_l.enLvl  = linkEnIn && l.cvS2;
        if (!linkPending && linkEnIn && l.cvS2) begin
            next_l.word = l.modeS2 ? {1'b1, 3'h0, serialTxBit} : {1'b0, txd};
            next_l.req  = ~l.req;
        end
    end

    always_ff @(posedge txLinkClk or negedge linkRstS2) begin
        if (!linkRstS2) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // Pop only at a bit boundary: a pop mid-countdown would stretch the last line bit
    assign run          = c.txClkValid && c.hwS2;
    assign fifoInValid  = (c.reqS2 != c.ack) && run;
    assign fifoOutReady = run && c.txDiv == 4'h0 &&
                          (c.txState == TX_IDLE || (c.txState == TX_SHIFT && c.txLeft == 3'h1));

    phydl_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rstS2),
        .clear    (!run),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (l.word),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOut)
    );

    // Core side: reset sequencing, line serializer, receive and carrier
    always_comb begin
        logic       hwAccept;
        logic       rxStart;
        logic       rxTick;
        logic [4:0] onBase;
        logic [1:0] cntBase;
        logic [NIB_W-1:0] shiftIn;
        hwAccept = 1'b0;
        rxStart  = 1'b0;
        rxTick   = 1'b0;
        onBase   = 5'h00;
        cntBase  = 2'h0;
        shiftIn  = '0;
        next_c   = c;

        // Pins pass two stages before use
        next_c.hwS1    = hardwareResetLow;
        next_c.hwS2    = c.hwS1;
        next_c.rxBitS1 = lineReceivePair;
        next_c.rxBitS2 = c.rxBitS1;
        next_c.rxValS1 = lineReceiveActive;
        next_c.rxValS2 = c.rxValS1;
        next_c.reqS1   = l.req;
        next_c.reqS2   = c.reqS1;
        next_c.enS1    = l.enLvl;
        next_c.enS2    = c.enS1;

        next_c.isolated = !c.hwS2;
        if (!c.hwS2) begin
            if (c.hwLowCnt != HWRST_MIN_CYC) begin
                next_c.hwLowCnt = c.hwLowCnt + 6'h1;
            end
        end else begin
            next_c.hwLowCnt = 6'h00;
        end
        hwAccept = !c.hwS2 && c.hwLowCnt == HWRST_MIN_CYC;

        if (!c.porDone) begin
            if (c.porCnt == POR_CYCLES - CNT_W'(1)) begin
                next_c.porDone = 1'b1;
            end else begin
                next_c.porCnt = c.porCnt + CNT_W'(1);
            end
        end

        if (hwAccept) begin
            next_c.cvCnt      = '0;
            next_c.txClkValid = 1'b0;
        end else if (c.porDone && c.hwS2 && !c.txClkValid) begin
            if (c.cvCnt == CLK_VALID_CYCLES - CNT_W'(1)) begin
                next_c.txClkValid = 1'b1;
            end else begin
                next_c.cvCnt = c.cvCnt + CNT_W'(1);
            end
        end

        // Return the toggle once the word is buffered
        if (fifoInValid && fifoInReady) begin
            next_c.ack = ~c.ack;
        end

        // one bit time per line bit
        case (c.txState)
            TX_IDLE: begin
                if (c.txDiv != 4'h0) begin
                    next_c.txDiv = c.txDiv - 4'h1;
                end else begin
                    next_c.lineTxEn = 1'b0;
                end
            end
            TX_SHIFT: begin
                if (c.txDiv != 4'h0) begin
                    next_c.txDiv = c.txDiv - 4'h1;
                end else begin
                    next_c.lineTx   = c.txShift[0];
                    next_c.lineTxEn = 1'b1;
                    next_c.txShift  = {1'b0, c.txShift[NIB_W-1:1]};
                    next_c.txLeft   = c.txLeft - 3'h1;
                    next_c.txDiv    = bitReload(speed100);
                    if (c.txLeft == 3'h1) begin
                        next_c.txState = TX_IDLE;
                    end
                end
            end
            default: begin
                next_c.txState = TX_IDLE;
            end
        endcase
        // Loading on the last bit keeps back-to-back words gapless
        if (fifoOutValid && fifoOutReady) begin
            next_c.txShift = fifoOut[NIB_W-1:0];
            next_c.txLeft  = fifoOut[WORD_SER] ? SER_BITS : NIB_BITS;
            next_c.txDiv   = bitReload(speed100);
            next_c.txState = TX_SHIFT;
        end

        // nibble assembly, first bit sampled at start
        next_c.rxPrev = c.rxValS2;
        rxStart = c.rxValS2 && !c.rxPrev;
        rxTick  = rxStart || (c.rxValS2 && c.rxDiv == 4'h0);
        onBase  = rxStart ? 5'h00 : c.rxOn;
        cntBase = rxStart ? 2'h0 : c.rxCnt;
        shiftIn = {c.rxBitS2, c.rxShift[NIB_W-1:1]};
        if (rxStart) begin
            next_c.rxOffRun = 1'b0;
        end
        if (rxTick) begin
            next_c.rxDiv   = bitReload(speed100);
            next_c.rxShift = shiftIn;
            next_c.rxCnt   = cntBase + 2'h1;
            if (cntBase == RX_NIB_LAST) begin
                next_c.rxd  = shiftIn;
                next_c.rxDv = 1'b1;
            end
            if (onBase != CRS_ON_BITS) begin
                next_c.rxOn = onBase + 5'h01;
            end else begin
                next_c.rxOn = onBase;
            end
        end else if (c.rxValS2) begin
            next_c.rxDiv = c.rxDiv - 4'h1;
        end else if (c.rxPrev) begin
            next_c.rxDv     = 1'b0;
            next_c.rxOffRun = 1'b1;
            next_c.rxOff    = 5'h00;
            next_c.rxDiv    = bitReload(speed100);
        end else if (c.rxOffRun) begin
            if (c.rxDiv != 4'h0) begin
                next_c.rxDiv = c.rxDiv - 4'h1;
            end else if (c.rxOff == CRS_OFF_BITS - 5'h01) begin
                next_c.rxOffRun = 1'b0;
                next_c.rxOn     = 5'h00;
            end else begin
                next_c.rxOff = c.rxOff + 5'h01;
                next_c.rxDiv = bitReload(speed100);
            end
        end

        // carrier from own transmit only in half duplex
        next_c.crs = (c.rxOn >= CRS_ON_BITS) || (!fullDuplex && c.enS2);
        next_c.col = !fullDuplex && (c.enS2 || c.lineTxEn) && (c.rxOn >= COL_ON_BITS);

        // crs, col, rxDv and line transmit quiet while isolated or initializing; rxd still follows the receive line
        if (!run) begin
            next_c.crs      = 1'b0;
            next_c.col      = 1'b0;
            next_c.rxDv     = 1'b0;
            next_c.lineTxEn = 1'b0;
            next_c.lineTx   = 1'b0;
            next_c.txState  = TX_IDLE;
            next_c.rxOn     = 5'h00;
            next_c.rxOffRun = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstS2) begin
        if (!rstS2) begin
            c         <= '0;
            c.hwS1    <= 1'b1;
            c.hwS2    <= 1'b1;
            c.txState <= TX_IDLE;
        end else begin
            c <= next_c;
        end
    end

    assign lineTransmitPair   = c.lineTx;
    assign lineTransmitEnable = c.lineTxEn;
    assign crs                = c.crs;
    assign col                = c.col;
    assign rxd                = c.rxd;
    assign rxDv               = c.rxDv;
    assign txClkValid         = c.txClkValid;
    assign isolated           = c.isolated;

endmodule : phydl_core

//--- phydl_core_properties.sv
module phydl_core_checker
    import phydl_pkg::*;
#(
    parameter logic [CNT_W-1:0] POR_CYCLES       = POR_CYC,
    parameter logic [CNT_W-1:0] CLK_VALID_CYCLES = CLKV_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic speed100,
    input wire logic fullDuplex,
    input wire logic txEn,
    input wire logic hardwareResetLow,
    input wire logic lineReceiveActive,
    input wire logic crs,
    input wire logic col,
    input wire logic txClkValid,
    input wire logic isolated
);
    localparam logic [CNT_W-1:0] LATE = POR_CYCLES + CLK_VALID_CYCLES + 26'h8;
    logic [CNT_W-1:0]            rstCnt;

    // Cycles since either reset; saturates so it never wraps into a false match
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rstCnt <= '0;
        else if (!hardwareResetLow)
            rstCnt <= '0;
        else if (rstCnt != '1)
            rstCnt <= rstCnt + 26'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    isolate_delay_a: assert property (
        $fell(hardwareResetLow) |-> ##[1:4] isolated) else $error("isolation late");
    fd_no_col_a: assert property (
        fullDuplex && $past(fullDuplex) |-> !col) else $error("collision in full duplex");
    own_carrier_a: assert property (
        !fullDuplex && $rose(txEn) |-> ##[1:12] crs) else $error("own carrier late");
    crs_on_a: assert property (
        speed100 && fullDuplex && !crs && $rose(lineReceiveActive) |-> !crs[*8] ##[2:6] crs)
        else $error("carrier on outside window");
    crs_off_a: assert property (
        speed100 && fullDuplex && $fell(lineReceiveActive) |-> crs[*8] ##1 crs[*4] ##[1:6] !crs)
        else $error("carrier off outside window");
    col_on_a: assert property (
        speed100 && !fullDuplex && txEn && !col && $rose(lineReceiveActive)
        |-> !col[*8] ##[2:5] col) else $error("collision on outside window");
    col_off_a: assert property (
        speed100 && col && $fell(lineReceiveActive) |-> col[*8] ##1 col[*4] ##[1:6] !col)
        else $error("collision off outside window");
    valid_early_a: assert property (
        $rose(txClkValid) |-> rstCnt >= CLK_VALID_CYCLES) else $error("clock valid early");
    valid_late_a: assert property (
        rstCnt == LATE |-> txClkValid) else $error("clock valid late");

    cover property ($rose(col));
    cover property (fullDuplex && $rose(crs));
    cover property ($rose(txClkValid) && rstCnt < POR_CYCLES + CLK_VALID_CYCLES);
endmodule : phydl_core_checker

bind phydl_core phydl_core_checker #(
    .POR_CYCLES(POR_CYCLES), .CLK_VALID_CYCLES(CLK_VALID_CYCLES)
) u_phydl_core_checker (
    .clk(clk), .nrst(nrst), .speed100(speed100), .fullDuplex(fullDuplex), .txEn(txEn),
    .hardwareResetLow(hardwareResetLow), .lineReceiveActive(lineReceiveActive),
    .crs(crs), .col(col), .txClkValid(txClkValid), .isolated(isolated)
);

//--- phydl_line_model.sv
module phydl_line_model
    import phydl_pkg::*;
(
    input  wire logic clk,
    input  wire logic speed100,
    input  wire logic serialMode,
    input  wire logic lineTransmitPair,
    input  wire logic lineTransmitEnable,
    output logic      lineReceivePair,
    output logic      lineReceiveActive
);
    timeunit 1ns;
    timeprecision 1ps;
    event             gotEv;
    logic [NIB_W-1:0] gotWord;
    logic [NIB_W-1:0] sh;
    int               bitCnt = 0;
    int               ph = 0;
    int               rph = 0;
    time              rxStart;
    bit               rxBits[$];

    initial lineReceiveActive = 1'b0;
    initial lineReceivePair = 1'b0;

    function automatic int bit_cyc();
        return speed100 ? 1 : 10;
    endfunction : bit_cyc

    // Queued so one process owns the pins; avoids a race with the idle toggle
    task automatic rx_frame(input logic [31:0] b);
        for (int i = 0; i < 32; i++)
            rxBits.push_back(b[i]);
    endtask : rx_frame

    always @(negedge clk) begin
        if (rph != 0)
            rph <= rph - 1;
        else if (rxBits.size() != 0) begin
            if (!lineReceiveActive)
                rxStart <= $time;
            lineReceiveActive <= 1'b1;
            lineReceivePair <= rxBits.pop_front();
            rph <= bit_cyc() - 1;
        end else begin
            lineReceiveActive <= 1'b0;
            lineReceivePair <= ~lineReceivePair; // Idle line shows no stale bit
        end
    end

    always @(negedge clk) begin
        if (!lineTransmitEnable) begin
            ph = 0;
            bitCnt = 0;
        end else begin
            if (ph == 0) begin
                sh[bitCnt] = lineTransmitPair;
                bitCnt++;
                if (serialMode || bitCnt == 4) begin
                    gotWord = serialMode ? NIB_W'(lineTransmitPair) : sh;
                    bitCnt = 0;
                    ->gotEv;
                end
            end
            ph = (ph + 1 == bit_cyc()) ? 0 : ph + 1;
        end
    end
endmodule : phydl_line_model

//--- phydl_core_tb.sv
module phydl_core_tb
    import phydl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk, nrst, txLinkClk, speed100, fullDuplex, serialMode, txEn;
    logic             serialTxEnable, serialTxBit, txAccept, hardwareResetLow, sawCol;
    logic             lineReceivePair, lineReceiveActive, lineTransmitPair, lineTransmitEnable;
    logic             crs, col, rxDv, txClkValid, isolated;
    logic [NIB_W-1:0] txd, rxd, txQ[$], rxQ[$];
    int               n_fail = 0, checks_done = 0, seed = 32'h8445, n, bc = 1;

    always #5 clk = ~clk;
    // Half-step offset keeps link edges clear of core edges
    initial begin
        txLinkClk = 1'b0;
        #2.5;
        forever #16 txLinkClk = ~txLinkClk;
    end
    always @(posedge clk) if (col === 1'b1) sawCol <= 1'b1;

    phydl_core #(.POR_CYCLES(26'h14), .CLK_VALID_CYCLES(26'h1E)) u_phydl_core (
        .clk(clk), .nrst(nrst), .txLinkClk(txLinkClk), .speed100(speed100),
        .fullDuplex(fullDuplex), .serialMode(serialMode), .txEn(txEn), .txd(txd),
        .serialTxEnable(serialTxEnable), .serialTxBit(serialTxBit), .txAccept(txAccept),
        .hardwareResetLow(hardwareResetLow), .lineReceivePair(lineReceivePair),
        .lineReceiveActive(lineReceiveActive), .lineTransmitPair(lineTransmitPair),
        .lineTransmitEnable(lineTransmitEnable), .crs(crs), .col(col), .rxd(rxd),
        .rxDv(rxDv), .txClkValid(txClkValid), .isolated(isolated));
    phydl_line_model u_phydl_line_model (
        .clk(clk), .speed100(speed100), .serialMode(serialMode),
        .lineTransmitPair(lineTransmitPair), .lineTransmitEnable(lineTransmitEnable),
        .lineReceivePair(lineReceivePair), .lineReceiveActive(lineReceiveActive));

    task automatic cmp_word(input string what, input logic [NIB_W-1:0] e, logic [NIB_W-1:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_word

    task automatic cmp_flag(input string what, input logic e, input logic g);
        cmp_word(what, NIB_W'(e), NIB_W'(g));
    endtask : cmp_flag

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic wait_valid(output int k);
        for (k = 0; k < 500 && txClkValid !== 1'b1; k++)
            @(negedge clk);
    endtask : wait_valid

    // Request held from a falling edge until the rising edge that takes it
    task automatic tx_word(input logic [NIB_W-1:0] w);
        int t;
        @(negedge txLinkClk);
        txEn = ~serialMode;
        txd = w;
        serialTxEnable = serialMode;
        serialTxBit = w[0];
        for (t = 0; t < 400 && txAccept !== 1'b1; t++)
            @(negedge txLinkClk);
        txQ.push_back(serialMode ? NIB_W'(w[0]) : w);
        @(posedge txLinkClk);
    endtask : tx_word

    // Transmit frame, with a receive frame overlapping it outside serial mode
    task automatic run_mode(input logic s100, input logic fd, input logic ser);
        logic [31:0] rb;
        @(negedge clk);
        speed100 = s100;
        fullDuplex = fd;
        serialMode = ser;
        sawCol = 1'b0;
        bc = s100 ? 1 : 10;
        rb = $random(seed);
        repeat (10) @(negedge clk);
        fork
            begin
                for (int i = 0; i < 12; i++) begin
                    tx_word(NIB_W'($random(seed)));
                    if (i == 2 && !ser)
                        cmp_flag("own carrier", ~fd, crs);
                end
                @(negedge txLinkClk);
                txEn = 1'b0;
                serialTxEnable = 1'b0;
            end
            if (!ser) begin
                repeat (60) @(negedge clk);
                for (int k = 0; k < 8; k++)
                    rxQ.push_back(rb[4 * k +: 4]);
                u_phydl_line_model.rx_frame(rb);
            end
        join
        for (n = 0; n < 3000 && txQ.size() != 0; n++)
            @(negedge clk);
        repeat (30 * bc) @(negedge clk);
        cmp_flag("tx drained", 1'b1, txQ.size() == 0);
        cmp_flag("collision", ~fd & ~ser, sawCol);
        cmp_flag("carrier idle", 1'b0, crs);
        rxQ.delete();
    endtask : run_mode

    task automatic hw_pulse(input int len, input logic taken);
        @(negedge clk);
        hardwareResetLow = 1'b0;
        repeat (4) @(negedge clk);
        cmp_flag("isolated", 1'b1, isolated);
        repeat (len - 4) @(negedge clk);
        hardwareResetLow = 1'b1;
        cmp_flag("clock valid", ~taken, txClkValid);
        wait_valid(n);
        cmp_flag("clock back", 1'b1, txClkValid);
        repeat (4) @(negedge clk);
        cmp_flag("isolated", 1'b0, isolated);
    endtask : hw_pulse

    // Line words in send order, LSB first
    always @(u_phydl_line_model.gotEv)
        if (txQ.size() != 0)
            cmp_word("line word", txQ.pop_front(), u_phydl_line_model.gotWord);
        else
            cmp_flag("spare line word", 1'b0, 1'b1);

    // Receive nibbles sampled just after each lands; the last has valid for one bit time only
    initial forever begin
        @(posedge rxDv);
        cmp_flag("rx latency", 1'b1, ($time - u_phydl_line_model.rxStart) <=
            (speed100 ? 170 : 700));
        #1;
        while (rxQ.size() != 0 && rxDv === 1'b1) begin
            cmp_word("rx nibble", rxQ.pop_front(), rxd);
            repeat (4 * bc) @(posedge clk);
            #1;
        end
    end

    initial begin
        #300000;
        n_fail++;
        test_done();
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        speed100 = 1'b1;
        fullDuplex = 1'b0;
        serialMode = 1'b0;
        txEn = 1'b0;
        txd = 4'h0;
        serialTxEnable = 1'b0;
        serialTxBit = 1'b0;
        hardwareResetLow = 1'b1;
        sawCol = 1'b0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        cmp_flag("clock valid", 1'b0, txClkValid);
        wait_valid(n);
        cmp_flag("power-on span", 1'b1, n >= 50);
        cmp_flag("clock valid", 1'b1, txClkValid);
        run_mode(1'b1, 1'b0, 1'b0);
        run_mode(1'b1, 1'b1, 1'b0);
        run_mode(1'b0, 1'b0, 1'b0);
        run_mode(1'b0, 1'b1, 1'b0);
        run_mode(1'b0, 1'b0, 1'b1);
        hw_pulse(70, 1'b1);
        hw_pulse(20, 1'b0);
        run_mode(1'b1, 1'b0, 1'b0);
        test_done();
    end
endmodule : phydl_core_tb
